// ==== rtl/bcs_cache_ctrl.sv ====
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - One shared 128-bit bidirectional data path for private and system transfers.
// - All SRAM controls except output enables are registered, sampled on SRAM clock.
// - Each access presents index, pulses address strobe, and edges SRAM clock.
// - SRAM clock rises the configured delay in CPU cycles after index launch.
// - Tag and data stores get separate asynchronous output enables.
// - A programmable gap separates a read from a following write; the OP_BYTEWR write phase follows its read after one ST_MERGE cycle instead.
// - Writes use early-write on the controller strobe; late-write never used.
// - Four active-low longword write enables, one per 32-bit lane.
// - Byte or word writes become read-modify-write sequences.
// - Tag write enable on fills, tag-writing moves, invalidates and clean-hit private writes.
// - Pipelined SRAMs return read data one SRAM clock later.
// - Private ownership uses the private ratio clock; system uses system clock.
// - Fill writes tag and data; victim reads data; move may write tag.
// - Private op table: which stores each private transaction reads or writes.
// - Latency is five plus offset bits 11:8; ratio from bits 7:4.
// - Private accesses may start on any CPU clock.
// - A read looks up tag with a speculative 32-byte, two-beat data read.
// - Strobe spans first private cycle; advance spans the second.
// - Output enables from cycle one; tag ends at latency, data latency plus ratio (one more ratio with pipelined SRAMs).
// - SRAM clock high 3 cycles above ratio 5, 2 for 3..5, 1 for 2.
// - Unused index lines driven low; only relevant tag bits compared.
// - Cache size field bits 13:12 selects half to four megabytes.
module bcs_cache_ctrl
  import bcs_pkg::*;
(
  input  wire logic                  clk_sys,        // CPU clock
  input  wire logic                  rst_n,          // Async reset
  input  wire logic                  clk_en,         // Freezes all state when low
  input  wire logic                  hsel,           // AHB select
  input  wire logic [31:0]           haddr,          // AHB address
  input  wire logic [1:0]            htrans,         // AHB transfer type
  input  wire logic                  hwrite,         // AHB write
  input  wire logic [2:0]            hsize,          // AHB size
  input  wire logic [31:0]           hwdata,         // AHB write data
  input  wire logic                  hready,         // AHB bus ready
  output logic                       hreadyout,      // AHB slave ready
  output logic [31:0]                hrdata,         // AHB read data
  output logic                       hresp,          // AHB response
  input  wire logic                  req_valid,      // Private request
  output logic                       req_ready,      // Private request taken
  input  wire bcs_pkg::bcs_req_t     req,            // Private request body
  output logic                       rsp_valid,      // Private answer pulse
  output bcs_pkg::bcs_rsp_t          rsp,            // Private answer body
  input  wire logic                  sys_req_valid,  // System transfer request
  output logic                       sys_req_ready,  // System request taken
  input  wire bcs_pkg::bcs_sys_req_t sys_req,        // System request body
  output logic                       sys_done,       // System transfer end pulse
  input  wire logic                  sys_own_pin,    // System owns cache
  input  wire logic                  sysclk_pin,     // System clock
  input  wire logic                  dack_pin,       // System data acknowledge
  output bcs_pkg::bcs_sram_ctl_t     sram_ctl,       // SRAM control pins
  output logic [15:0]                tag_out,        // Tag bus out {tag,valid,dirty}
  output logic                       tag_drv,        // Tag bus drive enable
  input  wire logic [15:0]           tag_in,         // Tag bus in
  output logic [127:0]               data_out,       // Data bus out
  output logic                       data_drv,       // Data bus drive enable
  input  wire logic [127:0]          data_in         // Data bus in
);
  import bcs_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [6:0] pulse_width(input logic [3:0] r);
    if (r > 4'h5) pulse_width = 7'h03;
    else if (r > 4'h2) pulse_width = 7'h02;
    else pulse_width = 7'h01;
  endfunction : pulse_width

  function automatic logic [TAG_W-1:0] tag_mask(input logic [1:0] s);
    tag_mask = {TAG_W{1'b1}} << s;
  endfunction : tag_mask

  function automatic logic [IDX_W-1:0] index_of(input logic [ADDR_W-1:0] a, input logic [1:0] s);
    logic [IDX_W-1:0] m;
    m = {IDX_W{1'b1}} >> (2'h3 - s);
    index_of = a[IDX_W-1:0] & m;
  endfunction : index_of

  // ==========================================================
  // Registers and AHB-Lite slave
  logic [31:0] cfg;
  logic [31:0] cfg2;
  logic        ap_wr;
  logic        ap_sel;
  logic [7:0]  ap_addr;
  logic        last_hit;
  logic        last_dirty;

  typedef enum {ST_IDLE, ST_GAP, ST_PRIV, ST_MERGE, ST_SYS} bcs_state_t;
  bcs_state_t  state;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ap_wr   <= 1'b0;
      ap_sel  <= 1'b0;
      ap_addr <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end else if (clk_en && hready) begin
      ap_sel  <= hsel && htrans[1];
      ap_wr   <= hsel && htrans[1] && hwrite;
      ap_addr <= haddr[7:0];
      hrdata  <= 32'h0000_0000;
      if (hsel && htrans[1] && !hwrite) begin
        case (haddr[7:0])
          ADDR_CONFIG:  hrdata <= cfg;
          ADDR_CONFIG2: hrdata <= cfg2;
          ADDR_STATUS:  hrdata <= {27'h0, sram_ctl.clk, last_dirty, last_hit, state == ST_SYS, state != ST_IDLE};
          default:      hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg  <= CONFIG_RST;
      cfg2 <= CONFIG2_RST;
    end else if (clk_en && ap_sel && ap_wr) begin
      if (ap_addr == ADDR_CONFIG) cfg <= hwdata;
      if (ap_addr == ADDR_CONFIG2) cfg2 <= hwdata;
    end
  end

  // Ratio below two is not serviceable; clamp it
  logic [3:0] ratio;
  logic [6:0] r7;
  logic [6:0] lat;
  logic [6:0] dly;
  logic [6:0] gap;
  logic [6:0] pw;
  logic [6:0] pl;
  logic [1:0] csize;
  assign ratio = (cfg[RATIO_LSB+:4] < RATIO_MIN) ? RATIO_MIN : cfg[RATIO_LSB+:4];
  assign r7    = {3'h0, ratio};
  assign lat   = LAT_BASE + {3'h0, cfg[LATOFF_LSB+:4]};
  assign dly   = {5'h00, cfg2[DELAY_LSB+:2]};
  assign gap   = {4'h0, cfg2[GAP_LSB+:3]} + 7'h01;
  assign pw    = pulse_width(ratio);
  assign pl    = cfg2[PIPE_BIT] ? r7 : 7'h00;
  assign csize = cfg[SIZE_LSB+:2];

  // ==========================================================
  // Pin synchronisers
  logic [2:0]   own_s;
  logic [2:0]   sck_s;
  logic [2:0]   ack_s;
  logic [15:0]  tag_s1;
  logic [15:0]  tag_s2;
  logic [127:0] dat_s1;
  logic [127:0] dat_s2;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      own_s  <= 3'h0;
      sck_s  <= 3'h0;
      ack_s  <= 3'h0;
      tag_s1 <= 16'h0000;
      tag_s2 <= 16'h0000;
      dat_s1 <= '0;
      dat_s2 <= '0;
    end else if (clk_en) begin
      own_s  <= {own_s[1:0], sys_own_pin};
      sck_s  <= {sck_s[1:0], sysclk_pin};
      ack_s  <= {ack_s[1:0], dack_pin};
      tag_s1 <= tag_in;
      tag_s2 <= tag_s1;
      dat_s1 <= data_in;
      dat_s2 <= dat_s1;
    end
  end

  logic sys_owns;
  logic sck_rise;
  logic ack_rise;
  assign sys_owns = own_s[1];
  assign sck_rise = sck_s[1] && !sck_s[2];
  assign ack_rise = ack_s[1] && !ack_s[2];

  // ==========================================================
  // Sequencer
  bcs_req_t     cur;
  bcs_sys_req_t scur;
  logic         rmw_rd;
  logic [6:0]   cyc;
  logic [2:0]   beats;
  logic         last_rd;
  logic [LINE_W-1:0] line;
  logic         hit_now;
  logic         is_wr_op;

  logic rd_data, rd_tag, wr_data, wr_tag;
  always_comb begin
    rd_data = (cur.op == OP_READ) || (cur.op == OP_BYTEWR && rmw_rd);
    rd_tag  = rd_data || cur.op == OP_WPROBE || cur.op == OP_SPROBE;
    wr_data = cur.op == OP_WDIRTY || cur.op == OP_WCLEAN
              || (cur.op == OP_BYTEWR && !rmw_rd);
    wr_tag  = cur.op == OP_WCLEAN || cur.op == OP_INVAL
              || (cur.op == OP_BYTEWR && !rmw_rd && !last_dirty);
  end

  logic [6:0] cap_tag, cap_b0, cap_b1, last_cyc;
  assign cap_tag  = lat - 7'h01 + SYNC_LAT;
  assign cap_b0   = lat - 7'h01 + pl + SYNC_LAT;
  assign cap_b1   = cap_b0 + r7;
  assign last_cyc = rd_data ? cap_b1 : (rd_tag ? cap_tag : r7 + r7);
  assign hit_now  = tag_s2[1] && (((tag_s2[15:2] ^ cur.addr[ADDR_W-1:ADDR_W-TAG_W])
                    & tag_mask(csize)) == '0);
  assign is_wr_op = req.op == OP_WDIRTY || req.op == OP_WCLEAN || req.op == OP_INVAL;

  logic launch_ok;
  // Private work waits while the system owns the cache
  assign launch_ok     = state == ST_IDLE && !sys_owns;
  // Taken even when a gap must follow, so a held request is never run twice
  assign req_ready     = launch_ok && req_valid;
  assign sys_req_ready = state == ST_IDLE && sys_owns && sck_rise;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cyc   <= 7'h00;
      beats <= 3'h0;
    end else if (clk_en) begin
      case (state)
        ST_IDLE: begin
          cyc   <= 7'h00;
          beats <= 3'h0;
          if (sys_req_ready && sys_req_valid) state <= ST_SYS;
          else if (req_ready) state <= (is_wr_op && last_rd) ? ST_GAP : ST_PRIV;
        end
        ST_GAP: begin
          cyc <= cyc + 7'h01;
          if (cyc + 7'h01 >= gap) begin
            state <= ST_PRIV;
            cyc   <= 7'h00;
          end
        end
        ST_PRIV: begin
          cyc <= cyc + 7'h01;
          if (cyc == last_cyc) begin
            cyc <= 7'h00;
            if (cur.op == OP_BYTEWR && rmw_rd) state <= last_hit ? ST_MERGE : ST_IDLE;
            else state <= ST_IDLE;
          end
        end
        ST_MERGE: state <= ST_PRIV;
        ST_SYS: begin
          if (ack_rise) beats <= beats + 3'h1;
          if (ack_rise && beats == SYS_BEATS - 3'h1) state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Request capture, RMW merge and read-to-write memory
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cur     <= '0;
      scur    <= '0;
      rmw_rd  <= 1'b0;
      last_rd <= 1'b0;
      line    <= '0;
    end else if (clk_en) begin
      if (state == ST_IDLE && req_valid && launch_ok && !(sys_req_ready && sys_req_valid)) begin
        cur    <= req;
        rmw_rd <= req.op == OP_BYTEWR;
      end
      if (sys_req_ready && sys_req_valid) scur <= sys_req;
      if (state == ST_PRIV && cyc == 7'h00) last_rd <= rd_data || rd_tag;
      if (state == ST_GAP) last_rd <= 1'b0;
      if (state == ST_PRIV && rd_data && cyc == cap_b0) line[127:0] <= dat_s2;
      if (state == ST_PRIV && rd_data && cyc == cap_b1) line[255:128] <= dat_s2;
      if (state == ST_MERGE) begin
        for (int b = 0; b < 32; b++)
          if (cur.bmask[b]) line[8*b+:8] <= cur.wdata[8*b+:8];
        rmw_rd <= 1'b0;
      end
    end
  end

  // Status and answer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      last_hit   <= 1'b0;
      last_dirty <= 1'b0;
      rsp_valid  <= 1'b0;
      rsp        <= '0;
      sys_done   <= 1'b0;
    end else if (clk_en) begin
      rsp_valid <= 1'b0;
      sys_done  <= state == ST_SYS && ack_rise && beats == SYS_BEATS - 3'h1;
      if (state == ST_PRIV && rd_tag && cyc == cap_tag) begin
        last_hit   <= hit_now;
        last_dirty <= tag_s2[0];
      end
      if (state == ST_PRIV && cyc == last_cyc && !(cur.op == OP_BYTEWR && rmw_rd && last_hit)) begin
        // Tag bus is released after the tag sample; use the captured result
        rsp_valid <= 1'b1;
        rsp.hit   <= (rd_tag && cyc == cap_tag) ? hit_now : last_hit;
        rsp.dirty <= (rd_tag && cyc == cap_tag) ? tag_s2[0] : last_dirty;
        rsp.rdata <= rd_data ? {dat_s2, line[127:0]} : line;
      end
    end
  end

  // ==========================================================
  // SRAM pin decode; registered so the SRAMs see clean edges
  bcs_sram_ctl_t next_ctl;
  logic [15:0]   next_tag;
  logic          next_tdrv;
  logic [127:0]  next_dat;
  logic          next_ddrv;
  logic          dbeat;

  always_comb begin
    next_ctl          = '{index: '0, adsc_n: 1'b1, adv_n: 1'b1, tag_oe_n: 1'b1,
                          data_oe_n: 1'b1, we_n: 4'hF, tag_we_n: 1'b1, clk: 1'b0};
    next_tag          = 16'h0000;
    next_tdrv         = 1'b0;
    next_dat          = 128'h0;
    next_ddrv         = 1'b0;
    dbeat             = cyc >= r7;
    if (state == ST_PRIV) begin
      next_ctl.index  = index_of(cur.addr, csize);
      next_ctl.adsc_n = !(cyc < r7);
      next_ctl.adv_n  = !((rd_data || wr_data) && dbeat && cyc < r7 + r7);
      next_ctl.tag_oe_n  = !(rd_tag && cyc >= 7'h01 && cyc < lat);
      next_ctl.data_oe_n = !(rd_data && cyc >= 7'h01 && cyc < lat + r7 + pl);
      next_ctl.clk    = (cyc >= dly && cyc < dly + pw)
                        || ((rd_data || wr_data) && cyc >= dly + r7 && cyc < dly + r7 + pw);
      if (wr_data && cyc < r7 + r7) begin
        next_ctl.we_n = 4'h0;
        next_ddrv     = 1'b1;
        next_dat      = dbeat ? line[255:128] : line[127:0];
        if (cur.op != OP_BYTEWR) next_dat = dbeat ? cur.wdata[255:128] : cur.wdata[127:0];
      end
      if (wr_tag && cyc < r7) begin
        next_ctl.tag_we_n = 1'b0;
        next_tdrv = 1'b1;
        next_tag  = {cur.addr[ADDR_W-1:ADDR_W-TAG_W] & tag_mask(csize), cur.op != OP_INVAL, cur.op != OP_INVAL};
      end
    end else if (state == ST_SYS) begin
      next_ctl.index  = index_of(scur.addr, csize);
      next_ctl.adsc_n = beats != 3'h0;
      next_ctl.adv_n  = beats == 3'h0;
      next_ctl.clk    = sck_s[1];
      if (scur.op == SYS_FILL) begin
        next_ctl.we_n     = 4'h0;
        next_ctl.tag_we_n = 1'b0;
        next_tdrv = 1'b1;
        next_tag  = {scur.addr[ADDR_W-1:ADDR_W-TAG_W] & tag_mask(csize), 1'b1, scur.dirty};
      end else begin
        next_ctl.data_oe_n = 1'b0;
        if (scur.op == SYS_MOVE && scur.tag_wr) begin
          next_ctl.tag_we_n = 1'b0;
          next_tdrv = 1'b1;
          next_tag  = {scur.addr[ADDR_W-1:ADDR_W-TAG_W] & tag_mask(csize), 1'b1, scur.dirty};
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sram_ctl <= '{index: '0, adsc_n: 1'b1, adv_n: 1'b1, tag_oe_n: 1'b1,
                    data_oe_n: 1'b1, we_n: 4'hF, tag_we_n: 1'b1, clk: 1'b0};
      tag_out  <= 16'h0000;
      tag_drv  <= 1'b0;
      data_out <= 128'h0;
      data_drv <= 1'b0;
    end else if (clk_en) begin
      sram_ctl <= next_ctl;
      tag_out  <= next_tag;
      tag_drv  <= next_tdrv;
      data_out <= next_dat;
      data_drv <= next_ddrv;
    end
  end

endmodule : bcs_cache_ctrl

`default_nettype wire

// ==== rtl/bcs_pkg.sv ====
package bcs_pkg;

  // ==========================================================
  // Register map (byte addresses on the AHB-Lite slave)
  localparam logic [7:0]  ADDR_CONFIG   = 8'h00;
  localparam logic [7:0]  ADDR_CONFIG2  = 8'h04;
  localparam logic [7:0]  ADDR_STATUS   = 8'h08;

  // ==========================================================
  // Field positions
  localparam int          RATIO_LSB     = 4;
  localparam int          LATOFF_LSB    = 8;
  localparam int          SIZE_LSB      = 12;
  localparam int          DELAY_LSB     = 0;
  localparam int          GAP_LSB       = 4;
  localparam int          PIPE_BIT      = 8;

  // ==========================================================
  // Reset values and timing counts
  localparam logic [31:0] CONFIG_RST    = 32'h0000_3030;
  localparam logic [31:0] CONFIG2_RST   = 32'h0000_0000;
  localparam logic [6:0]  LAT_BASE      = 7'h05;
  localparam logic [3:0]  RATIO_MIN     = 4'h2;
  localparam logic [6:0]  SYNC_LAT      = 7'h03;
  localparam logic [2:0]  SYS_BEATS     = 3'h4;

  // ==========================================================
  // Address split
  localparam int          IDX_W         = 18;
  localparam int          TAG_W         = 14;
  localparam int          ADDR_W        = 29;
  localparam int          LINE_W        = 256;

  typedef enum logic [2:0] {
    OP_READ, OP_WPROBE, OP_SPROBE, OP_WDIRTY, OP_WCLEAN, OP_INVAL, OP_BYTEWR
  } bcs_op_t;

  typedef enum logic [1:0] {SYS_FILL, SYS_VICTIM, SYS_MOVE} bcs_sys_op_t;

  typedef struct packed {
    bcs_op_t             op;
    logic [ADDR_W-1:0]   addr;
    logic [LINE_W-1:0]   wdata;
    logic [31:0]         bmask;
  } bcs_req_t;

  typedef struct packed {
    bcs_sys_op_t         op;
    logic [ADDR_W-1:0]   addr;
    logic                tag_wr;
    logic                dirty;
  } bcs_sys_req_t;

  typedef struct packed {
    logic [LINE_W-1:0]   rdata;
    logic                hit;
    logic                dirty;
  } bcs_rsp_t;

  typedef struct packed {
    logic [IDX_W-1:0]    index;
    logic                adsc_n;
    logic                adv_n;
    logic                tag_oe_n;
    logic                data_oe_n;
    logic [3:0]          we_n;
    logic                tag_we_n;
    logic                clk;
  } bcs_sram_ctl_t;

endpackage : bcs_pkg

// ==== testbench/bcs_cache_ctrl_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========
// Pin checks
module bcs_cache_ctrl_asserts
  import bcs_pkg::*;
(
  input wire logic                   clk_sys,       // Clock
  input wire logic                   rst_n,         // Reset
  input wire logic                   hreadyout,     // Ready
  input wire logic                   hresp,         // Response
  input wire logic                   req_ready,     // Taken
  input wire logic                   rsp_valid,     // Answer
  input wire logic                   sys_req_ready, // Sys taken
  input wire logic                   sys_own_pin,   // Sys owns
  input wire logic                   tag_drv,       // Tag drive
  input wire logic                   data_drv,      // Data drive
  input wire bcs_pkg::bcs_sram_ctl_t sram_ctl       // SRAM pins
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_ahb_zero_wait: assert property (hreadyout)
    else $error("slave stalled");
  chk_ahb_okay: assert property (!hresp)
    else $error("error response");
  chk_tag_contend: assert property (!(tag_drv && !sram_ctl.tag_oe_n))
    else $error("tag bus contention");
  chk_data_contend: assert property (!(data_drv && !sram_ctl.data_oe_n))
    else $error("data bus contention");
  chk_we_oe_excl: assert property ((sram_ctl.we_n != 4'hF) |-> sram_ctl.data_oe_n)
    else $error("write while data output on");
  chk_index_hold: assert property (!sram_ctl.adsc_n && !$past(sram_ctl.adsc_n) |-> $stable(sram_ctl.index))
    else $error("index moved under strobe");
  chk_strobe_clock: assert property ($fell(sram_ctl.adsc_n) |-> ##[0:3] sram_ctl.clk)
    else $error("no sram clock after strobe");
  chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
  chk_own_blocks: assert property (sys_own_pin [*3] |-> !req_ready)
    else $error("private taken while system owns");
  chk_sys_refused: assert property (!sys_own_pin [*3] |-> !sys_req_ready)
    else $error("system taken without ownership");
endmodule : bcs_cache_ctrl_asserts
bind bcs_cache_ctrl bcs_cache_ctrl_asserts u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .hreadyout(hreadyout),
  .hresp(hresp), .req_ready(req_ready), .rsp_valid(rsp_valid), .sys_req_ready(sys_req_ready),
  .sys_own_pin(sys_own_pin), .tag_drv(tag_drv), .data_drv(data_drv), .sram_ctl(sram_ctl));
`default_nettype wire

// ==== testbench/bcs_sram_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========
// Flow-through burst SRAM pair
module bcs_sram_model
  import bcs_pkg::*;
(
  input wire logic                   clk_sys, // Clock
  input wire bcs_pkg::bcs_sram_ctl_t ctl,     // Pins
  input wire logic [127:0]           dout,    // Ctrl data
  input wire logic                   ddrv,    // Ctrl drives
  input wire logic [15:0]            tout,    // Ctrl tag
  input wire logic                   tdrv,    // Ctrl drives tag
  input wire logic [4:0]             lag,     // Read access lag in cycles
  output logic [127:0]               din,     // Data bus
  output logic [15:0]                tin      // Tag bus
);
  logic [127:0] mem [32];
  logic [15:0]  tmem [16];
  logic [127:0] dl;
  logic [15:0]  tl;
  logic [4:0]   base;
  logic [3:0]   ta;
  logic [1:0]   cnt;
  logic         ck_q = 1'b0;
  // Output follows the latched address by lag cycles, as a slow array would
  logic [4:0]   hist [24];
  initial for (int i = 0; i < 32; i++) mem[i] = {4{32'h12345600 + i}};
  initial for (int i = 0; i < 16; i++) tmem[i] = 16'h0002;
  always @(posedge clk_sys) begin
    if (ctl.clk && !ck_q) begin
      if (!ctl.adsc_n) {base, cnt} = {ctl.index[4:0], 2'h0};
      else if (!ctl.adv_n) cnt = cnt + 2'h1;
      ta = ctl.index[4:1];
      if (!ctl.tag_we_n) tmem[ta] = tout;
      // Early write: data lands at the same edge as the address
      for (int l = 0; l < 4; l++) if (!ctl.we_n[l]) mem[base ^ cnt][32*l+:32] = dout[32*l+:32];
    end
    ck_q = ctl.clk;
    for (int h = 23; h > 0; h--) hist[h] = hist[h - 1];
    hist[0] = base ^ cnt;
    dl = din;
    tl = tin;
  end
  // Released bus toggles so a stale value cannot pass
  assign din = ddrv ? dout : !ctl.data_oe_n ? mem[hist[lag]] : ~dl;
  assign tin = tdrv ? tout : !ctl.tag_oe_n ? tmem[ta] : ~tl;
endmodule : bcs_sram_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========
// Bench
module tb_top;
  import bcs_pkg::*;
  logic          clk_sys = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, req_valid = 1'b0, dack_pin = 1'b0;
  logic          sys_req_valid = 1'b0, sys_own_pin = 1'b0, sysclk_pin = 1'b0, sys_drv = 1'b0, adsc_q = 1'b1;
  logic          hreadyout, hresp, req_ready, rsp_valid, sys_req_ready, sys_done, tag_drv, data_drv, risen, pwd;
  logic [31:0]   haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]    htrans = 2'h0;
  logic [4:0]    lag = 5'h00;
  logic [15:0]   tag_out, tag_in;
  logic [127:0]  data_out, data_in, m_din, sys_d = 128'h0;
  bcs_req_t      req = '0;
  bcs_rsp_t      rsp;
  bcs_sys_req_t  sys_req = '0;
  bcs_sram_ctl_t sram_ctl;
  int            failures = 0, compares = 0, dly, pw, toe, doe, twe, wec, dn;
  bcs_cache_ctrl dut_u (.*, .clk_en(1'b1), .hsize(3'h2), .hready(hreadyout));
  bcs_sram_model m_u (.clk_sys(clk_sys), .ctl(sram_ctl), .dout(data_out), .ddrv(data_drv), .tout(tag_out),
    .tdrv(tag_drv), .lag(lag), .din(m_din), .tin(tag_in));
  assign data_in = sys_drv ? sys_d : m_din;
  always #4 clk_sys = ~clk_sys;
  always #80 sysclk_pin = ~sysclk_pin;
  // Per-access pin timing, restarted at each strobe
  always @(posedge clk_sys) begin
    if (!sram_ctl.adsc_n && adsc_q) {dly, pw, toe, doe, twe, wec, dn, risen, pwd} = '0;
    adsc_q = sram_ctl.adsc_n;
    if (!risen && !sram_ctl.clk) dly++;
    risen |= sram_ctl.clk;
    if (sram_ctl.clk && !pwd) pw++;
    pwd |= risen && !sram_ctl.clk;
    toe += !sram_ctl.tag_oe_n;
    doe += !sram_ctl.data_oe_n;
    twe += !sram_ctl.tag_we_n;
    wec += (sram_ctl.we_n != 4'hF);
    dn += sys_done;
  end
  function automatic logic [127:0] pat(input int i);
    return {4{32'h12345600 + i}};
  endfunction : pat
  task automatic give_verdict;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [259:0] got, input logic [259:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input int s);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while ((s == 0 ? hreadyout : s == 1 ? req_ready : s == 2 ? rsp_valid : sys_req_ready) !== 1'b1
               && n < 3000);
    if (n >= 3000) begin
      failures++;
      give_verdict();
    end
  endtask : wt
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wt(0);
    htrans <= 2'h0;
    hwdata <= wd;
    wt(0);
    rd = hrdata;
  endtask : ahb
  task automatic priv(input bcs_op_t op, input int k, input logic [255:0] wd, input logic [31:0] bm);
    req <= '{op: op, addr: 29'(2 * k), wdata: wd, bmask: bm};
    req_valid <= 1'b1;
    wt(1);
    req_valid <= 1'b0;
    if (rsp_valid !== 1'b1) wt(2);
  endtask : priv
  task automatic rd_chk(input int k, input logic [255:0] exp, input logic [1:0] hd);
    priv(OP_READ, k, '0, '0);
    chk({rsp.hit, rsp.dirty, rsp.rdata}, {hd, exp});
  endtask : rd_chk
  task automatic timing;
    int r [4] = '{3, 2, 6, 4};
    int o [4] = '{0, 2, 1, 0};
    int d [4] = '{0, 1, 3, 0};
    int p [4] = '{2, 1, 3, 2};
    for (int i = 0; i < 4; i++) begin
      // Last pass selects pipelined SRAMs
      ahb(1'b1, ADDR_CONFIG, 32'h3000 | (o[i] << 8) | (r[i] << 4));
      ahb(1'b1, ADDR_CONFIG2, 32'(d[i] + (i / 3) * 256));
      lag <= 5'(3 + o[i] - d[i] + (i / 3) * r[i]);
      rd_chk(i + 1, {pat(2 * i + 3), pat(2 * i + 2)}, 2'b10);
      chk({dly, pw, toe, doe}, {d[i], p[i], 4 + o[i], 4 + o[i] + r[i] + (i / 3) * r[i]});
    end
  endtask : timing
  task automatic writes;
    logic [255:0] w1, w2;
    w1 = ~{pat(21), pat(20)};
    w2 = {pat(30), pat(31)};
    priv(OP_WCLEAN, 5, w1, '0);
    chk({twe > 0, wec > 0, m_u.tmem[5]}, {2'b11, 16'h0003});
    rd_chk(5, w1, 2'b11);
    priv(OP_WDIRTY, 5, w2, '0);
    chk({twe > 0, m_u.mem[11], m_u.mem[10]}, {1'b0, w2});
    priv(OP_BYTEWR, 5, ~w2, 32'h1);
    rd_chk(5, {w2[255:8], ~w2[7:0]}, 2'b11);
    for (int i = 0; i < 2; i++) begin
      priv(i ? OP_SPROBE : OP_WPROBE, 5, '0, '0);
      chk({doe, wec, twe, toe > 0}, {96'h0, 1'b1});
    end
    priv(OP_INVAL, 5, '0, '0);
    chk({doe, wec, twe > 0, m_u.tmem[5][1]}, {64'h0, 2'b10});
  endtask : writes
  task automatic system;
    sys_own_pin <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      sys_req <= '{op: s ? SYS_VICTIM : SYS_FILL, addr: 29'h10, tag_wr: !s, dirty: 1'b0};
      sys_req_valid <= 1'b1;
      wt(3);
      sys_req_valid <= 1'b0;
      // Slow acknowledge pacing, clear of the synchroniser latency
      for (int b = 0; b < 4; b++) begin
        sys_d <= pat(40 + b);
        sys_drv <= !s;
        repeat (4) @(posedge clk_sys);
        dack_pin <= 1'b1;
        repeat (6) @(posedge clk_sys);
        dack_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
      end
      sys_drv <= 1'b0;
      chk({dn, twe > 0, doe > 0}, {32'd1, !s, s[0]});
    end
    sys_own_pin <= 1'b0;
  endtask : system
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    ahb(1'b0, ADDR_CONFIG, 32'h0);
    chk(rd, CONFIG_RST);
    ahb(1'b0, ADDR_CONFIG2, 32'h0);
    chk(rd, CONFIG2_RST);
    ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    timing();
    writes();
    system();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
